// >>> core/ssp_status_rx.sv
// Status flags and receive path of a synchronous framed serial port.
// Assumes an APB master on clk and a transmit framer on clk giving slot pulses.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
// Functional notes
// RULE1: Word transfer to holding sets receive full
// RULE2: Holding register read clears receive full
// RULE3: Receive interrupt while enabled and full
// RULE4: Transmit empty set on load or null
// RULE5: All enabled writes or null clear empty
// RULE6: Transmit interrupt when empty and enabled
// RULE7: Transfer while full sets overrun
// RULE8: Overrun interrupt when error enable set
// RULE9: Status read then data read clears overrun
// RULE10: Slot with missing data sets underrun
// RULE11: Underrun resends words still held
// RULE12: One slot normal, up to 32 network
// RULE13: Underrun interrupt when error enable set
// RULE14: Status read then writes clear underrun
// RULE15: First slot flag for received word
// RULE16: Transmit first slot flag per slot
// RULE17: Word written in first slot goes second
// RULE18: Control line one sampled into flag
// RULE19: Control line zero sampled into flag
// RULE20: Shift on bit clock, selectable order
// RULE21: Transfer after selected word length
// RULE22: Holding alignment bit 23 or 15
// RULE23: Status writes ignored, reads only arm
module ssp_status_rx (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB slave
	input wire logic [ssp_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ssp_pkg::APB_DW-1:0] pwdata,
	output logic [ssp_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link pins
	input wire logic bitClkPin,
	input wire logic frameSyncPin,
	input wire logic rxDataPin,
	input wire logic ctlLineZeroPin,
	input wire logic ctlLineOnePin,
	// Transmit framer
	input wire logic txSlotStart,
	input wire logic txFrameStart,
	output logic [ssp_pkg::NUM_TX*ssp_pkg::HOLD_W-1:0] txShiftData,
	output logic txShiftLoad,
	output logic txNullSlot,
	// Interrupt requests
	output logic rxIrq,
	output logic txIrq,
	output logic rxErrIrq,
	output logic txErrIrq
);
	import ssp_pkg::*;

	link_if lnk();

	logic [CTRL_W-1:0] ctrl_q;
	logic [APB_DW-1:0] prdata_q;
	logic pslverr_q;
	rxstate_t rxState_q;
	logic [5:0] bitCnt_q;
	logic [4:0] slotCnt_q;
	logic [31:0] shift_q;
	logic firstSlot_q;
	logic [1:0] ifLatch_q;
	logic wordDone_q;
	logic [HOLD_W-1:0] hold_q;
	logic rxFull_q;
	logic rxOverrun_q;
	logic overrunArm_q;
	logic rxFirst_q;
	logic flagZero_q;
	logic flagOne_q;
	logic [HOLD_W-1:0] txData_q [NUM_TX];
	logic [NUM_TX-1:0] txWritten_q;
	logic nullPending_q;
	logic txEmpty_q;
	logic txUnderrun_q;
	logic underrunArm_q;
	logic txFirst_q;
	logic [4:0] txSlotCnt_q;
	logic [NUM_TX*HOLD_W-1:0] txShiftData_q;
	logic txShiftLoad_q;
	logic txNull_q;

	// Pin synchroniser and bit clock edge finder
	link_sampler u_sampler (
		.clk(clk),
		.srst(srst),
		.bitClkPin(bitClkPin),
		.frameSyncPin(frameSyncPin),
		.rxDataPin(rxDataPin),
		.ctlLineZeroPin(ctlLineZeroPin),
		.ctlLineOnePin(ctlLineOnePin),
		.link(lnk.src)
	);

	// Control fields
	wordlen_t wordLen;
	logic shiftLsbFirst;
	logic alignLow;
	logic networkMode;
	logic syncMode;
	logic rxEnable;
	logic [NUM_TX-1:0] txEnable;
	assign wordLen = wordlen_t'(ctrl_q[CT_WL +: 3]);
	assign shiftLsbFirst = ctrl_q[CT_SHFT];
	assign alignLow = ctrl_q[CT_ALIGN];
	assign networkMode = ctrl_q[CT_NET];
	assign syncMode = ctrl_q[CT_SYNC];
	assign rxEnable = ctrl_q[CT_RXEN];
	assign txEnable = ctrl_q[CT_TXEN +: NUM_TX];

	// Bus decode; the slave never waits, so every access phase completes
	logic access;
	logic busWrite;
	logic statusRead;
	logic rxRead;
	logic nullWrite;
	logic [NUM_TX-1:0] txWrite;
	assign access = psel & penable;
	assign busWrite = access & pwrite;
	assign statusRead = access & ~pwrite & (paddr == ADDR_STATUS);
	assign rxRead = access & ~pwrite & (paddr == ADDR_RXDATA);
	assign nullWrite = busWrite & (paddr == ADDR_NULLSLOT);
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// One write strobe per transmit data register
	always_comb begin
		for (int i = 0; i < NUM_TX; i++) begin
			txWrite[i] = busWrite & (paddr == ADDR_TX0 + 8'(i) * ADDR_TX_STEP);
		end
	end

	// Word length in bit clocks
	function automatic logic [5:0] wordBits(input wordlen_t wl);
		case (wl)
			WL_8: wordBits = 6'd8;
			WL_12: wordBits = 6'd12;
			WL_16: wordBits = 6'd16;
			WL_24: wordBits = 6'd24;
			WL_32: wordBits = 6'd32;
			default: wordBits = 6'd8;
		endcase
	endfunction

	logic [5:0] wlBits;
	logic [5:0] wlLast;
	assign wlBits = wordBits(wordLen);
	assign wlLast = wlBits - 6'd1;

	// Input flag enables: line is a port input flag in synchronous mode
	logic flagZeroEnable;
	logic flagOneEnable;
	assign flagZeroEnable = syncMode & ~txEnable[1] & ~ctrl_q[CT_DIR0] & ctrl_q[CT_PORT0];
	assign flagOneEnable = syncMode & ~txEnable[2] & ~ctrl_q[CT_DIR1] & ctrl_q[CT_PORT1];

	// Status word as software sees it; frame flags only mean something when enabled
	logic [7:0] statusVal;
	logic txFirstShown;
	assign txFirstShown = (txEnable != 3'b000) & (networkMode ? txFirst_q : 1'b1);
	assign statusVal = {rxFull_q, txEmpty_q, rxOverrun_q, txUnderrun_q, rxFirst_q & rxEnable, txFirstShown,
		flagOne_q, flagZero_q};

	// Control register write
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= CTRL_RESET;
		end else if (busWrite && paddr == ADDR_CTRL) begin
			ctrl_q <= pwdata[CTRL_W-1:0];
		end
	end

	// Read data is built in the setup phase so it comes from flops
	// RULE23: status is read only
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_q <= 1'b0;
			case (paddr)
				ADDR_CTRL: prdata_q <= {13'h0000, ctrl_q};
				ADDR_STATUS: prdata_q <= {24'h000000, statusVal};
				ADDR_RXDATA: prdata_q <= {8'h00, hold_q};
				ADDR_NULLSLOT, ADDR_TX0, ADDR_TX0 + ADDR_TX_STEP,
				ADDR_TX0 + ADDR_TX_STEP + ADDR_TX_STEP: prdata_q <= 32'h00000000;
				default: begin
					prdata_q <= 32'h00000000;
					pslverr_q <= 1'b1;
				end
			endcase
		end
	end

	// Receive word state: idle until frame sync, network runs up to the last slot
	always_ff @(posedge clk) begin
		if (srst) begin
			rxState_q <= RX_IDLE;
		end else if (!rxEnable) begin
			rxState_q <= RX_IDLE;
		end else if (lnk.bitStrobe) begin
			case (rxState_q)
				RX_IDLE: begin
					if (lnk.frameSync) begin
						rxState_q <= RX_SHIFT;
					end
				end
				RX_SHIFT: begin
					if (bitCnt_q == wlLast && !(networkMode && slotCnt_q != LAST_SLOT)) begin
						rxState_q <= RX_IDLE;
					end
				end
				default: rxState_q <= RX_IDLE;
			endcase
		end
	end

	// Shift register and bit count
	logic shiftNow;
	assign shiftNow = rxEnable & lnk.bitStrobe & ((rxState_q == RX_SHIFT) | lnk.frameSync);

	always_ff @(posedge clk) begin
		if (srst) begin
			bitCnt_q <= 6'd0;
			slotCnt_q <= 5'd0;
			shift_q <= 32'h00000000;
			firstSlot_q <= 1'b0;
			ifLatch_q <= 2'b00;
			wordDone_q <= 1'b0;
		end else begin
			wordDone_q <= 1'b0;
			if (!rxEnable) begin
				bitCnt_q <= 6'd0;
			end else if (shiftNow) begin
				// RULE20: order selectable
				shift_q <= shiftLsbFirst ? {lnk.rxBit, shift_q[31:1]} : {shift_q[30:0], lnk.rxBit};
				if (bitCnt_q == 6'd0) begin
					// RULE18: latch line one
					// RULE19: latch line zero
					ifLatch_q <= {lnk.ctlOne, lnk.ctlZero};
					firstSlot_q <= lnk.frameSync;
					slotCnt_q <= lnk.frameSync ? 5'd0 : slotCnt_q + 5'd1;
				end
				// RULE21: word length count
				if (bitCnt_q == wlLast) begin
					bitCnt_q <= 6'd0;
					wordDone_q <= 1'b1;
				end else begin
					bitCnt_q <= bitCnt_q + 6'd1;
				end
			end
		end
	end

	// Completed word, MSB at the top in both orders
	logic [31:0] aligned32;
	logic [HOLD_W-1:0] holdNext;
	// LSB first leaves older bits below the word; masked so unused bits read zero
	assign aligned32 = shiftLsbFirst ? (shift_q & ~(32'hffffffff >> wlBits)) : (shift_q << (6'd32 - wlBits));
	// RULE22: align to bit 23 or 15
	assign holdNext = alignLow ? {8'h00, aligned32[31:16]} : aligned32[31:8];

	// Holding register; a read in the same cycle frees it for the new word
	always_ff @(posedge clk) begin
		if (srst) begin
			hold_q <= HOLD_RESET;
		end else if (wordDone_q && (!rxFull_q || rxRead)) begin
			hold_q <= holdNext;
		end
	end

	// Receive full; a transfer beats a read in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			rxFull_q <= 1'b0;
		end else if (wordDone_q) begin
			// RULE1: set on transfer
			rxFull_q <= 1'b1;
		end else if (rxRead) begin
			// RULE2: read clears
			rxFull_q <= 1'b0;
		end
	end

	// Overrun: the old word is kept, the new one is dropped
	always_ff @(posedge clk) begin
		if (srst) begin
			rxOverrun_q <= 1'b0;
			overrunArm_q <= 1'b0;
		end else begin
			if (statusRead && prdata_q[ST_OVERRUN]) begin
				overrunArm_q <= 1'b1;
			end else if (rxRead) begin
				overrunArm_q <= 1'b0;
			end
			if (wordDone_q && rxFull_q && !rxRead) begin
				// RULE7: transfer while full
				rxOverrun_q <= 1'b1;
			end else if (rxRead && overrunArm_q) begin
				// RULE9: two step clear
				rxOverrun_q <= 1'b0;
			end
		end
	end

	// Frame and input flags follow each transfer
	always_ff @(posedge clk) begin
		if (srst) begin
			rxFirst_q <= 1'b0;
			flagZero_q <= 1'b0;
			flagOne_q <= 1'b0;
		end else begin
			if (wordDone_q) begin
				// RULE15: first slot of frame
				rxFirst_q <= networkMode ? firstSlot_q : 1'b1;
			end
			// RULE19: copy or hold cleared
			if (!flagZeroEnable) begin
				flagZero_q <= 1'b0;
			end else if (wordDone_q) begin
				flagZero_q <= ifLatch_q[0];
			end
			// RULE18: copy or hold cleared
			if (!flagOneEnable) begin
				flagOne_q <= 1'b0;
			end else if (wordDone_q) begin
				flagOne_q <= ifLatch_q[1];
			end
		end
	end

	// Transmit slot acceptance
	logic txSlot;
	logic allWritten;
	logic txRefill;
	logic underrun;
	// RULE12: slots per frame
	assign txSlot = txSlotStart & (txEnable != 3'b000) &
		(txFrameStart | (networkMode & (txSlotCnt_q != LAST_SLOT)));
	assign allWritten = (txEnable != 3'b000) && (((txWritten_q | txWrite) & txEnable) == txEnable);
	assign txRefill = allWritten | nullWrite;
	assign underrun = ((txEnable & ~txWritten_q) != 3'b000) & ~nullPending_q;

	// Transmit data registers keep their word so an underrun resends it
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NUM_TX; i++) begin
				txData_q[i] <= HOLD_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_TX; i++) begin
				if (txWrite[i]) begin
					txData_q[i] <= pwdata[HOLD_W-1:0];
				end
			end
		end
	end

	// Slot bookkeeping; a write on the slot edge counts for the next slot
	always_ff @(posedge clk) begin
		if (srst) begin
			txWritten_q <= 3'b000;
			nullPending_q <= 1'b0;
			txSlotCnt_q <= 5'd0;
			txFirst_q <= 1'b0;
			txShiftData_q <= '0;
			txShiftLoad_q <= 1'b0;
			txNull_q <= 1'b0;
		end else begin
			txShiftLoad_q <= txSlot;
			if (txSlot) begin
				// RULE11: resend held words
				// RULE17: loaded at next slot
				for (int i = 0; i < NUM_TX; i++) begin
					txShiftData_q[i*HOLD_W +: HOLD_W] <= txData_q[i];
				end
				txNull_q <= nullPending_q;
				nullPending_q <= nullWrite;
				txWritten_q <= txWrite;
				txSlotCnt_q <= txFrameStart ? 5'd0 : txSlotCnt_q + 5'd1;
				// RULE16: first slot flag
				txFirst_q <= txFrameStart;
			end else begin
				txWritten_q <= txWritten_q | txWrite;
				if (nullWrite) begin
					nullPending_q <= 1'b1;
				end
			end
		end
	end

	// Transmit empty; a slot load beats a refill in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			txEmpty_q <= 1'b0;
		end else if (txSlot) begin
			// RULE4: set on load or null
			txEmpty_q <= 1'b1;
		end else if (txRefill) begin
			// RULE5: refill clears
			txEmpty_q <= 1'b0;
		end
	end

	// Underrun with its two step clear
	always_ff @(posedge clk) begin
		if (srst) begin
			txUnderrun_q <= 1'b0;
			underrunArm_q <= 1'b0;
		end else begin
			if (statusRead && prdata_q[ST_UNDERRUN]) begin
				underrunArm_q <= 1'b1;
			end else if (txRefill) begin
				underrunArm_q <= 1'b0;
			end
			if (txSlot && underrun) begin
				// RULE10: slot without data
				txUnderrun_q <= 1'b1;
			end else if (underrunArm_q && txRefill) begin
				// RULE14: two step clear
				txUnderrun_q <= 1'b0;
			end
		end
	end

	assign txShiftData = txShiftData_q;
	assign txShiftLoad = txShiftLoad_q;
	assign txNullSlot = txNull_q;

	// Interrupt requests are levels that follow flag and enable
	// RULE3: receive request
	assign rxIrq = ctrl_q[CT_RX_IRQ] & rxFull_q;
	// RULE6: transmit request
	assign txIrq = ctrl_q[CT_TX_IRQ] & txEmpty_q;
	// RULE8: overrun request
	assign rxErrIrq = ctrl_q[CT_RX_ERR] & rxOverrun_q;
	// RULE13: underrun request
	assign txErrIrq = ctrl_q[CT_TX_ERR] & txUnderrun_q;

endmodule

// >>> core/ssp_pkg.sv
// Package for the serial port status and receive block.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
package ssp_pkg;

	// Bus widths
	localparam int APB_AW = 8;
	localparam int APB_DW = 32;
	localparam int HOLD_W = 24;
	localparam int CTRL_W = 19;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_RXDATA = 8'h08;
	localparam logic [7:0] ADDR_NULLSLOT = 8'h0c;
	localparam logic [7:0] ADDR_TX0 = 8'h10;
	localparam logic [7:0] ADDR_TX_STEP = 8'h04;

	// Status bit positions
	localparam int ST_RX_FULL = 7;
	localparam int ST_TX_EMPTY = 6;
	localparam int ST_OVERRUN = 5;
	localparam int ST_UNDERRUN = 4;
	localparam int ST_RX_FIRST = 3;
	localparam int ST_TX_FIRST = 2;
	localparam int ST_FLAG_ONE = 1;
	localparam int ST_FLAG_ZERO = 0;

	// Control bit positions
	localparam int CT_WL = 0;
	localparam int CT_SHFT = 3;
	localparam int CT_ALIGN = 4;
	localparam int CT_NET = 5;
	localparam int CT_SYNC = 6;
	localparam int CT_RXEN = 7;
	localparam int CT_TXEN = 8;
	localparam int CT_DIR0 = 11;
	localparam int CT_DIR1 = 12;
	localparam int CT_PORT0 = 13;
	localparam int CT_PORT1 = 14;
	localparam int CT_RX_IRQ = 15;
	localparam int CT_TX_IRQ = 16;
	localparam int CT_RX_ERR = 17;
	localparam int CT_TX_ERR = 18;

	// Reset values and counts
	localparam logic [CTRL_W-1:0] CTRL_RESET = 19'h00000;
	localparam logic [HOLD_W-1:0] HOLD_RESET = 24'h000000;
	localparam int NUM_TX = 3;
	localparam logic [4:0] LAST_SLOT = 5'h1f;

	// Word length settings
	typedef enum logic [2:0] {
		WL_8 = 3'b000,
		WL_12 = 3'b001,
		WL_16 = 3'b010,
		WL_24 = 3'b011,
		WL_32 = 3'b100
	} wordlen_t;

	// Receive word state
	typedef enum logic [0:0] {
		RX_IDLE = 1'b0,
		RX_SHIFT = 1'b1
	} rxstate_t;

endpackage

// >>> core/link_if.sv
// Interface carrying synchronised serial link levels and the bit strobe.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface link_if;
	logic bitStrobe;
	logic frameSync;
	logic rxBit;
	logic ctlZero;
	logic ctlOne;
	modport src(output bitStrobe, frameSync, rxBit, ctlZero, ctlOne);
	modport dst(input bitStrobe, frameSync, rxBit, ctlZero, ctlOne);
endinterface

// >>> core/link_sampler.sv
// Synchroniser and bit clock edge finder for the serial link pins.
// Assumes the link clock is far slower than clk (several clk per half period).
`timescale 1ns/10ps
module link_sampler (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Link pins
	input wire logic bitClkPin,
	input wire logic frameSyncPin,
	input wire logic rxDataPin,
	input wire logic ctlLineZeroPin,
	input wire logic ctlLineOnePin,
	// Sampled link
	link_if.src link
);
	logic [4:0] meta_q;
	logic [4:0] sync_q;
	logic clkPrev_q;

	// Two stages per pin; only the second stage feeds logic
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= 5'h00;
			sync_q <= 5'h00;
			clkPrev_q <= 1'b0;
		end else begin
			meta_q <= {ctlLineOnePin, ctlLineZeroPin, rxDataPin, frameSyncPin, bitClkPin};
			sync_q <= meta_q;
			clkPrev_q <= sync_q[0];
		end
	end

	// Rising bit clock edge; data pins share the same delay so they line up
	assign link.bitStrobe = sync_q[0] & ~clkPrev_q;
	assign link.frameSync = sync_q[1];
	assign link.rxBit = sync_q[2];
	assign link.ctlZero = sync_q[3];
	assign link.ctlOne = sync_q[4];

endmodule

// >>> dv/ssp_status_rx_asserts.sv
// Checker for the serial port status and receive block, bound to its top.
// Assumes the control word changes only through APB writes to its offset.
`timescale 1ns/10ps
module ssp_status_rx_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB
	input wire logic [ssp_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ssp_pkg::APB_DW-1:0] pwdata,
	input wire logic [ssp_pkg::APB_DW-1:0] prdata,
	input wire logic pslverr,
	// Transmit framer
	input wire logic txSlotStart,
	input wire logic txFrameStart,
	input wire logic [ssp_pkg::NUM_TX*ssp_pkg::HOLD_W-1:0] txShiftData,
	input wire logic txShiftLoad,
	// Interrupts
	input wire logic rxIrq,
	input wire logic txIrq,
	input wire logic rxErrIrq,
	input wire logic txErrIrq
);
	import ssp_pkg::*;
	logic [CTRL_W-1:0] ctrl_q;
	logic rxRead;
	// Shadow of the control word, so irq levels can be tied to their enables
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= CTRL_RESET;
		end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
			ctrl_q <= pwdata[CTRL_W-1:0];
		end
	end
	assign rxRead = psel && penable && !pwrite && paddr == ADDR_RXDATA;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// Register access
	status_no_error_a: assert property (psel && penable && paddr == ADDR_STATUS |-> !pslverr)
		else $error("status access flagged an error");
	rx_top_zero_a: assert property (rxRead |-> prdata[31:24] == 8'h00)
		else $error("holding read has upper byte set");
	rx_read_clear_a: assert property (rxRead |=> !rxIrq)
		else $error("receive irq stays after holding read");
	// Interrupt gating by the enables
	rx_irq_gate_a: assert property (rxIrq |-> ctrl_q[CT_RX_IRQ])
		else $error("receive irq without enable");
	tx_irq_gate_a: assert property (txIrq |-> ctrl_q[CT_TX_IRQ])
		else $error("transmit irq without enable");
	rx_err_gate_a: assert property (rxErrIrq |-> ctrl_q[CT_RX_ERR])
		else $error("overrun irq without enable");
	tx_err_gate_a: assert property (txErrIrq |-> ctrl_q[CT_TX_ERR])
		else $error("underrun irq without enable");
	// Slot acceptance and transmit data holding
	load_sets_empty_a: assert property (txShiftLoad && ctrl_q[CT_TX_IRQ] |-> txIrq)
		else $error("slot load left transmit irq low");
	slot_accept_a: assert property (txShiftLoad |-> $past(txSlotStart && (txFrameStart || ctrl_q[CT_NET])))
		else $error("load without an acceptable slot");
	shift_hold_a: assert property ($changed(txShiftData) |-> txShiftLoad || $past(srst))
		else $error("shift data changed outside a slot");
	// Main scenarios reached
	overrun_seen_c: cover property (rxErrIrq);
	underrun_seen_c: cover property (txErrIrq);
	load_seen_c: cover property (txShiftLoad && txIrq);
endmodule

bind ssp_status_rx ssp_status_rx_asserts chk (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.txSlotStart(txSlotStart), .txFrameStart(txFrameStart), .txShiftData(txShiftData),
	.txShiftLoad(txShiftLoad), .rxIrq(rxIrq), .txIrq(txIrq), .rxErrIrq(rxErrIrq), .txErrIrq(txErrIrq));

// >>> dv/codec_model.sv
// Behavioural framed serial codec driving the receive side of the link.
// Assumes one caller at a time; the bit clock stands still between frames.
`timescale 1ns/10ps
module codec_model #(
	parameter real HALF_NS = 62.5
) (
	// Link outputs
	output logic bitClk,
	output logic frameSync,
	output logic dataOut,
	output logic ctlZero,
	output logic ctlOne
);
	// Idle link levels at time zero
	initial begin
		bitClk = 1'b0;
		frameSync = 1'b0;
		dataOut = 1'b0;
		ctlZero = 1'b0;
		ctlOne = 1'b0;
	end
	// Send one frame of cnt words; frame sync marks only the first bit
	task automatic sendFrame(input logic [31:0] w0, input logic [31:0] w1, input int cnt, input int nb,
		input bit lsb, input logic f0, input logic f1);
		logic [31:0] w;
		int idx;
		for (int k = 0; k < cnt; k++) begin
			w = (k == 0) ? w0 : w1;
			for (int i = 0; i < nb; i++) begin
				idx = lsb ? i : nb - 1 - i;
				dataOut = w[idx];
				frameSync = (k == 0 && i == 0);
				ctlZero = f0;
				ctlOne = f1;
				#(HALF_NS);
				bitClk = 1'b1;
				#(HALF_NS);
				bitClk = 1'b0;
			end
		end
		// Released line shows no stale bit
		frameSync = 1'b0;
		dataOut = ~dataOut;
	endtask
endmodule

// >>> dv/test_sync_serial_status_receive.sv
// Self-checking bench for the serial port status and receive block.
// Assumes the codec model feeds the link; the bench is APB master and framer.
`timescale 1ns/10ps
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin failCount++; \
	$display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module test_sync_serial_status_receive;
	import ssp_pkg::*;
	localparam logic [CTRL_W-1:0] RX_BASE = 19'h2e0c0; // Rx on, sync, input flags, rx irqs
	localparam logic [CTRL_W-1:0] TX_BASE = 19'h50100; // Tx0 on, tx irqs
	localparam logic [CTRL_W-1:0] NET = 19'h00020;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic txSlotStart = 1'b0;
	logic txFrameStart = 1'b0;
	logic bitClk, frameSync, rxData, ctl0, ctl1;
	logic [31:0] prdata;
	logic pready, pslverr, txShiftLoad, txNullSlot, rxIrq, txIrq, rxErrIrq, txErrIrq;
	logic [NUM_TX*HOLD_W-1:0] txShiftData;
	logic [32:0] expQ[$];
	logic [32:0] expHead;
	int failCount = 0;
	int testsRun = 0;

	always #5 clk = ~clk;

	ssp_status_rx dut (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bitClkPin(bitClk), .frameSyncPin(frameSync), .rxDataPin(rxData), .ctlLineZeroPin(ctl0),
		.ctlLineOnePin(ctl1), .txSlotStart(txSlotStart), .txFrameStart(txFrameStart),
		.txShiftData(txShiftData), .txShiftLoad(txShiftLoad), .txNullSlot(txNullSlot),
		.rxIrq(rxIrq), .txIrq(txIrq), .rxErrIrq(rxErrIrq), .txErrIrq(txErrIrq));
	codec_model codec (.bitClk(bitClk), .frameSync(frameSync), .dataOut(rxData), .ctlZero(ctl0),
		.ctlOne(ctl1));

	// One APB transfer; the trailing edge lets status updates land before checks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// One framer slot pulse, then a settling edge
	task automatic slot(input logic first);
		@(posedge clk);
		txSlotStart <= 1'b1;
		txFrameStart <= first;
		@(posedge clk);
		txSlotStart <= 1'b0;
		@(posedge clk);
	endtask
	// Bounded wait for a receive interrupt level
	task automatic waitRx(input bit err);
		int n;
		n = 0;
		while ((err ? rxErrIrq : rxIrq) !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
	endtask
	// Holding word: top bits kept, MSB at 23 or at 15
	function automatic logic [31:0] holdExp(input logic [31:0] v, input int nb, input bit al);
		int w;
		logic [31:0] m;
		w = al ? 16 : 24;
		m = (nb == 32) ? v : v & ((32'h1 << nb) - 32'h1);
		return (nb >= w) ? m >> (nb - w) : m << (w - nb);
	endfunction
	task automatic reportAndStop();
		$display("Comparisons %0d, mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Read results are compared in completion order against the noted values
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready && expQ.size() > 0) begin
			expHead = expQ.pop_front();
			`CHK({pslverr, prdata}, expHead)
		end
	end

	// Watchdog: the sequence needs fewer than two thousand cycles
	initial begin
		repeat (40000) @(posedge clk);
		failCount++;
		reportAndStop();
	end

	// Main sequence
	initial begin
		logic [31:0] w0, w1;
		logic f0, f1;
		bit sh, al;
		int nb;
		void'($urandom(32'h5081effd));
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rd(ADDR_CTRL, 33'h0);
		rd(ADDR_STATUS, 33'h0);
		rd(8'h40, {1'b1, 32'h0});
		$display("Test reset done");
		// Every word length, both bit orders and both alignments
		for (int wl = 0; wl < 5; wl++) begin
			nb = (wl < 3) ? 8 + 4 * wl : (wl == 3 ? 24 : 32);
			sh = wl % 2;
			al = (wl / 2) % 2;
			w0 = $urandom();
			f0 = 1'($urandom_range(1));
			f1 = 1'($urandom_range(1));
			wr(ADDR_CTRL, 32'(RX_BASE | 19'(wl) | (19'(sh) << CT_SHFT) | (19'(al) << CT_ALIGN)));
			codec.sendFrame(w0, w0, 1, nb, sh, f0, f1);
			waitRx(1'b0);
			`CHK(rxIrq, 1'b1)
			rd(ADDR_STATUS, {25'h0, 8'h88 | {6'h0, f1, f0}});
			rd(ADDR_RXDATA, {1'b0, holdExp(w0, nb, al)});
			`CHK(rxIrq, 1'b0)
		end
		$display("Test receive done");
		// Second word while full; holding read alone keeps the overrun
		w0 = $urandom();
		w1 = $urandom();
		wr(ADDR_CTRL, 32'(RX_BASE));
		codec.sendFrame(w0, w0, 1, 8, 1'b0, 1'b1, 1'b0);
		waitRx(1'b0);
		codec.sendFrame(w1, w1, 1, 8, 1'b0, 1'b1, 1'b0);
		waitRx(1'b1);
		`CHK(rxErrIrq, 1'b1)
		rd(ADDR_RXDATA, {9'h0, w0[7:0], 16'h0});
		`CHK(rxErrIrq, 1'b1)
		rd(ADDR_STATUS, {25'h0, 8'h29});
		rd(ADDR_RXDATA, {9'h0, w0[7:0], 16'h0});
		`CHK(rxErrIrq, 1'b0)
		$display("Test overrun done");
		// Network frame of two words, first slot marked
		wr(ADDR_CTRL, 32'(RX_BASE | NET));
		fork
			codec.sendFrame(w0, w1, 2, 8, 1'b0, 1'b0, 1'b0);
			begin
				waitRx(1'b0);
				rd(ADDR_STATUS, {25'h0, 8'h88});
				rd(ADDR_RXDATA, {9'h0, w0[7:0], 16'h0});
				waitRx(1'b0);
				rd(ADDR_STATUS, {25'h0, 8'h80});
				rd(ADDR_RXDATA, {9'h0, w1[7:0], 16'h0});
			end
		join
		$display("Test network receive done");
		// Transmit load, underrun resend and the two clearing sequences
		wr(ADDR_CTRL, 32'(TX_BASE));
		wr(ADDR_TX0, w0);
		slot(1'b1);
		`CHK(txShiftData[23:0], w0[23:0])
		`CHK(txIrq, 1'b1)
		rd(ADDR_STATUS, {25'h0, 8'h44});
		slot(1'b1);
		`CHK(txErrIrq, 1'b1)
		`CHK(txShiftData[23:0], w0[23:0])
		wr(ADDR_TX0, w1);
		`CHK(txIrq, 1'b0)
		`CHK(txErrIrq, 1'b1)
		rd(ADDR_STATUS, {25'h0, 8'h14});
		wr(ADDR_TX0, w1);
		`CHK(txErrIrq, 1'b0)
		wr(ADDR_STATUS, 32'hffffffff);
		rd(ADDR_STATUS, {25'h0, 8'h04});
		slot(1'b1);
		`CHK(txShiftData[23:0], w1[23:0])
		wr(ADDR_NULLSLOT, 32'h0);
		`CHK(txIrq, 1'b0)
		slot(1'b1);
		`CHK(txNullSlot, 1'b1)
		`CHK(txIrq, 1'b1)
		`CHK(txErrIrq, 1'b0)
		slot(1'b0);
		wr(ADDR_CTRL, 32'(TX_BASE | NET));
		wr(ADDR_TX0, w0);
		slot(1'b0);
		rd(ADDR_STATUS, {25'h0, 8'h40});
		$display("Test transmit done");
		reportAndStop();
	end
endmodule
